/* File: hdl/exs_pkg.sv */
// package: constants, encodings and types for the exception entry sequencer
package exs_pkg;

	// ----------------------------------------
	// vector numbers
	// ----------------------------------------
	localparam logic [7:0] VEC_POR_PC      = 8'h00;
	localparam logic [7:0] VEC_POR_SP      = 8'h01;
	localparam logic [7:0] VEC_MAN_PC      = 8'h02;
	localparam logic [7:0] VEC_MAN_SP      = 8'h03;
	localparam logic [7:0] VEC_GEN_ILLEGAL = 8'h04;
	localparam logic [7:0] VEC_SLOT_ILLEGAL = 8'h06;
	localparam logic [7:0] VEC_CPU_ADDR_ERR = 8'h09;
	localparam logic [7:0] VEC_DMA_ADDR_ERR = 8'h0a;
	localparam logic [7:0] VEC_NMI         = 8'h0b;
	localparam logic [7:0] VEC_USER_BREAK  = 8'h0c;

	// ----------------------------------------
	// status word layout and reset values
	// ----------------------------------------
	localparam int          MASK_LSB       = 4;
	localparam logic [3:0]  MASK_RESET_VAL = 4'hf;
	localparam logic [31:0] VBR_RESET_VAL  = 32'h0000_0000;
	localparam logic [31:0] WORD_BYTES     = 32'h0000_0004;
	localparam logic [1:0]  VEC_SHIFT      = 2'h2;

	// ----------------------------------------
	// decoded instruction classes
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_OTHER, OP_UNDEFINED,
		OP_JUMP, OP_JUMP_SUB, OP_BRANCH, OP_BRANCH_SUB, OP_RETURN_SUB, OP_RETURN_EXC,
		OP_BRANCH_FALSE_DLY, OP_BRANCH_TRUE_DLY, OP_BRANCH_SUB_FAR, OP_BRANCH_FAR,
		OP_BRANCH_TRUE, OP_BRANCH_FALSE, OP_SOFTWARE_TRAP
	} exs_op_type;

	// ----------------------------------------
	// selected source
	// ----------------------------------------
	typedef enum logic [3:0] {
		SRC_NONE, SRC_POR, SRC_MANUAL, SRC_CPU_AE, SRC_DMA_AE, SRC_NMI, SRC_UBRK,
		SRC_IRQ, SRC_PERIPH, SRC_TRAP, SRC_GEN_ILL, SRC_SLOT_ILL
	} exs_src_type;

	typedef enum {
		ST_IDLE, ST_RST_PC, ST_RST_SP, ST_PUSH_SR, ST_PUSH_PC, ST_VEC, ST_DONE
	} exs_state_type;

	// ----------------------------------------
	// delayed branch opcodes
	// ----------------------------------------
	function automatic logic exs_is_delayed(input exs_op_type op);
		exs_is_delayed = op inside {OP_JUMP, OP_JUMP_SUB, OP_BRANCH, OP_BRANCH_SUB, OP_RETURN_SUB,
			OP_RETURN_EXC, OP_BRANCH_FALSE_DLY, OP_BRANCH_TRUE_DLY, OP_BRANCH_SUB_FAR, OP_BRANCH_FAR};
	endfunction : exs_is_delayed

	// ----------------------------------------
	// opcodes that rewrite the program counter
	// ----------------------------------------
	function automatic logic exs_rewrites_pc(input exs_op_type op);
		exs_rewrites_pc = exs_is_delayed(op) || op inside {OP_BRANCH_TRUE, OP_BRANCH_FALSE, OP_SOFTWARE_TRAP};
	endfunction : exs_rewrites_pc

	function automatic logic [31:0] exs_vec_offset(input logic [7:0] vec);
		exs_vec_offset = {22'h0, vec, VEC_SHIFT'(2'h0)} ;
	endfunction : exs_vec_offset

endpackage : exs_pkg

/* File: hdl/exs_sequencer.sv */
// exception entry sequencer: ranks sources, fetches vectors, stacks state
//
// Contract
// RULE1 - serve pending sources: resets, address errors, interrupts, instruction exceptions
// RULE2 - within groups: power-on, manual; cpu, dma; nmi, break, irq, peripheral; trap, illegal, slot
// RULE3 - power-on starts on its pin rising; manual on its pin rising with power-on high
// RULE4 - address errors and interrupts start only after the running instruction completes
// RULE5 - software trap starts when the trap instruction executes
// RULE6 - undefined code outside a delay slot raises general illegal
// RULE7 - undefined or pc-rewriting code in a delay slot raises slot illegal
// RULE8 - the ten delayed branch classes each open a checked delay slot
// RULE9 - delayed branches plus conditional branches and trap rewrite the pc
// RULE10 - power-on fetches pc from word 0 and sp from word 4
// RULE11 - manual reset fetches pc from word 8 and sp from word 12
// RULE12 - reset clears vector base and sets the mask field to all ones
// RULE13 - after reset, execution starts at the fetched pc
// RULE14 - non-reset entry pushes status word and pc on the stack
// RULE15 - interrupt entry loads the accepted level into the mask field
// RULE16 - address error and instruction entry keep the mask field
// RULE17 - non-reset entry fetches the handler address and jumps there
// RULE18 - vector address is base plus four times number; resets use no base
// RULE19 - power-on resets peripherals too; manual reset only the cpu
// RULE20 - lower sources stay pending and are judged again at next acceptance; the code drops a pending manual reset when power-on is accepted
`timescale 1ns/1ps
module exs_sequencer
	import exs_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// reset pins
	input  wire logic              power_on_reset_pin_n_i,
	input  wire logic              manual_reset_pin_n_i,
	// pipeline side
	input  wire exs_op_type        dec_op_i,
	input  wire logic              dec_valid_i,
	input  wire logic              insn_done_i,
	input  wire logic [7:0]        trap_vec_i,
	input  wire logic [31:0]       pc_i,
	input  wire logic [31:0]       sp_i,
	input  wire logic [31:0]       status_word_i,
	// address error and interrupt sources
	input  wire logic              cpu_addr_err_i,
	input  wire logic              dma_addr_err_i,
	input  wire logic              nmi_i,
	input  wire logic              user_break_i,
	input  wire logic              irq_i,
	input  wire logic [7:0]        irq_vec_i,
	input  wire logic [3:0]        irq_level_i,
	input  wire logic              periph_i,
	input  wire logic [7:0]        periph_vec_i,
	input  wire logic [3:0]        periph_level_i,
	input  wire logic [3:0]        nmi_level_i,
	input  wire logic [3:0]        ubrk_level_i,
	// memory bus
	output logic                   mem_req_o,
	output logic                   mem_we_o,
	output logic [ADDR_W-1:0]      mem_addr_o,
	output logic [31:0]            mem_wdata_o,
	input  wire logic              mem_ack_i,
	input  wire logic [31:0]       mem_rdata_i,
	// results to the cpu
	output logic                   pipe_hold_o,
	output logic                   redirect_o,
	output logic [31:0]            new_pc_o,
	output logic                   sp_we_o,
	output logic [31:0]            new_sp_o,
	output logic [31:0]            vector_base_reg_o,
	output logic [31:0]            status_word_o,
	output logic                   periph_reset_o,
	output logic                   ack_src_o,
	output exs_src_type            ack_src_kind_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		exs_state_type st;
		exs_src_type   src;
		logic          por_prev_n;
		logic          man_prev_n;
		logic          por_pend;
		logic          man_pend;
		logic          in_slot;
		logic          trap_pend;
		logic          gen_pend;
		logic          slot_pend;
		logic [7:0]    trap_vec;
		logic [7:0]    vec;
		logic [3:0]    level;
		logic [31:0]   sp;
		logic [31:0]   pc;
		logic [31:0]   vector_base_reg;
		logic [31:0]   sw;
		logic          mem_req;
		logic          mem_we;
		logic [31:0]   mem_addr;
		logic [31:0]   mem_wdata;
		logic          redirect;
		logic [31:0]   new_pc;
		logic          sp_we;
		logic [31:0]   new_sp;
		logic          periph_rst;
		logic          ack;
	} exs_regs_type;

	exs_regs_type r;
	exs_regs_type next_r;

	function automatic logic [31:0] set_mask(input logic [31:0] sw, input logic [3:0] lvl);
		logic [31:0] v;
		v = sw;
		v[MASK_LSB +: 4] = lvl;
		set_mask = v;
	endfunction : set_mask

	always_comb begin
		logic [3:0]  lvl;
		logic        take;
		logic        async_ok;
		lvl = 4'h0;
		take = 1'b0;
		async_ok = 1'b0;
		next_r = r;
		next_r.redirect = 1'b0;
		next_r.sp_we = 1'b0;
		next_r.ack = 1'b0;
		next_r.periph_rst = 1'b0;
		next_r.por_prev_n = power_on_reset_pin_n_i;
		next_r.man_prev_n = manual_reset_pin_n_i;
		// address errors and interrupts wait for the running instruction and
		// never split a branch from its delay slot
		async_ok = insn_done_i && !r.in_slot; // RULE4
		take = 1'b1;
		unique case (r.st)
			ST_IDLE: begin
				// RULE1 RULE2 RULE20: first match wins, the rest stay pending except manual reset, which power-on clears
				if (r.por_pend) begin
					next_r.src = SRC_POR;
					next_r.por_pend = 1'b0;
					next_r.man_pend = 1'b0;
					next_r.periph_rst = 1'b1; // RULE19
				end else if (r.man_pend) begin
					next_r.src = SRC_MANUAL;
					next_r.man_pend = 1'b0;
				end else if (async_ok && cpu_addr_err_i) begin
					next_r.src = SRC_CPU_AE;
					next_r.vec = VEC_CPU_ADDR_ERR;
				end else if (async_ok && dma_addr_err_i) begin
					next_r.src = SRC_DMA_AE;
					next_r.vec = VEC_DMA_ADDR_ERR;
				end else if (async_ok && nmi_i) begin
					next_r.src = SRC_NMI;
					next_r.vec = VEC_NMI;
					lvl = nmi_level_i;
				end else if (async_ok && user_break_i) begin
					next_r.src = SRC_UBRK;
					next_r.vec = VEC_USER_BREAK;
					lvl = ubrk_level_i;
				end else if (async_ok && irq_i) begin
					next_r.src = SRC_IRQ;
					next_r.vec = irq_vec_i;
					lvl = irq_level_i;
				end else if (async_ok && periph_i) begin
					next_r.src = SRC_PERIPH;
					next_r.vec = periph_vec_i;
					lvl = periph_level_i;
				end else if (r.trap_pend) begin
					next_r.src = SRC_TRAP;
					next_r.vec = r.trap_vec;
					next_r.trap_pend = 1'b0;
				end else if (r.gen_pend) begin
					next_r.src = SRC_GEN_ILL;
					next_r.vec = VEC_GEN_ILLEGAL;
					next_r.gen_pend = 1'b0;
				end else if (r.slot_pend) begin
					next_r.src = SRC_SLOT_ILL;
					next_r.vec = VEC_SLOT_ILLEGAL;
					next_r.slot_pend = 1'b0;
				end else begin
					take = 1'b0;
				end
				next_r.level = lvl;
				if (take && power_on_reset_pin_n_i) begin
					next_r.ack = 1'b1;
					next_r.in_slot = 1'b0;
					next_r.mem_req = 1'b1;
					next_r.mem_we = 1'b0;
					if (r.por_pend || r.man_pend) begin
						next_r.st = ST_RST_PC;
						// RULE10 RULE11 RULE18: reset vectors use no base
						next_r.mem_addr = exs_vec_offset(r.por_pend ? VEC_POR_PC : VEC_MAN_PC);
					end else begin
						next_r.st = ST_PUSH_SR;
						next_r.pc = pc_i;
						next_r.sw = status_word_i;
						next_r.sp = sp_i - WORD_BYTES;
						next_r.mem_we = 1'b1;
						next_r.mem_addr = sp_i - WORD_BYTES; // RULE14
						next_r.mem_wdata = status_word_i;
					end
				end
			end
			ST_RST_PC: if (mem_ack_i) begin
				next_r.new_pc = mem_rdata_i;
				next_r.mem_addr = exs_vec_offset(r.src == SRC_POR ? VEC_POR_SP : VEC_MAN_SP);
				next_r.st = ST_RST_SP;
			end
			ST_RST_SP: if (mem_ack_i) begin
				next_r.mem_req = 1'b0;
				next_r.new_sp = mem_rdata_i;
				next_r.sp_we = 1'b1;
				next_r.vector_base_reg = VBR_RESET_VAL; // RULE12
				next_r.sw = set_mask(r.sw, MASK_RESET_VAL); // RULE12
				next_r.redirect = 1'b1; // RULE13
				next_r.st = ST_DONE;
			end
			ST_PUSH_SR: if (mem_ack_i) begin
				next_r.sp = r.sp - WORD_BYTES;
				next_r.mem_addr = r.sp - WORD_BYTES;
				next_r.mem_wdata = r.pc; // RULE14
				next_r.st = ST_PUSH_PC;
			end
			ST_PUSH_PC: if (mem_ack_i) begin
				next_r.mem_we = 1'b0;
				next_r.mem_addr = r.vector_base_reg + exs_vec_offset(r.vec); // RULE18
				next_r.st = ST_VEC;
			end
			ST_VEC: if (mem_ack_i) begin
				next_r.mem_req = 1'b0;
				next_r.new_pc = mem_rdata_i;
				next_r.new_sp = r.sp;
				next_r.sp_we = 1'b1;
				// RULE15 RULE16
				if (r.src inside {SRC_NMI, SRC_UBRK, SRC_IRQ, SRC_PERIPH}) begin
					next_r.sw = set_mask(r.sw, r.level);
				end
				next_r.redirect = 1'b1; // RULE17
				next_r.st = ST_DONE;
			end
			ST_DONE: next_r.st = ST_IDLE;
		endcase
		// latches come after acceptance so a new event in the clearing cycle wins
		// pin edges are latched so a busy sequencer never misses one
		if (!r.por_prev_n && power_on_reset_pin_n_i) begin
			next_r.por_pend = 1'b1; // RULE3
		end
		if (!r.man_prev_n && manual_reset_pin_n_i && power_on_reset_pin_n_i) begin
			next_r.man_pend = 1'b1; // RULE3
		end
		// instruction-caused sources, tracked per decoded instruction
		if (dec_valid_i && r.st == ST_IDLE) begin
			next_r.in_slot = exs_is_delayed(dec_op_i); // RULE8
			if (r.in_slot && (dec_op_i == OP_UNDEFINED || exs_rewrites_pc(dec_op_i))) begin
				next_r.slot_pend = 1'b1; // RULE7 RULE9
			end else if (dec_op_i == OP_UNDEFINED) begin
				next_r.gen_pend = 1'b1; // RULE6
			end else if (dec_op_i == OP_SOFTWARE_TRAP) begin
				next_r.trap_pend = 1'b1; // RULE5
				next_r.trap_vec = trap_vec_i;
			end
		end
		// a held power-on pin aborts any entry in flight
		if (!power_on_reset_pin_n_i) begin
			next_r.st = ST_IDLE;
			next_r.mem_req = 1'b0;
			next_r.redirect = 1'b0;
			next_r.sp_we = 1'b0;
			next_r.periph_rst = 1'b1; // RULE19
			next_r.trap_pend = 1'b0;
			next_r.gen_pend = 1'b0;
			next_r.slot_pend = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '{st: ST_IDLE, src: SRC_NONE, por_prev_n: 1'b1, man_prev_n: 1'b1,
				vector_base_reg: VBR_RESET_VAL, sw: {{(32 - MASK_LSB - 4){1'b0}}, MASK_RESET_VAL, 4'h0},
				default: '0};
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign mem_req_o         = r.mem_req;
	assign mem_we_o          = r.mem_we;
	assign mem_addr_o        = r.mem_addr[ADDR_W-1:0];
	assign mem_wdata_o       = r.mem_wdata;
	assign pipe_hold_o       = (r.st != ST_IDLE);
	assign redirect_o        = r.redirect;
	assign new_pc_o          = r.new_pc;
	assign sp_we_o           = r.sp_we;
	assign new_sp_o          = r.new_sp;
	assign vector_base_reg_o = r.vector_base_reg;
	assign status_word_o     = r.sw;
	assign periph_reset_o    = r.periph_rst;
	assign ack_src_o         = r.ack;
	assign ack_src_kind_o    = r.src;

endmodule : exs_sequencer

/* File: dv/exs_mem_model.sv */
// memory partner for the exception entry sequencer
`timescale 1ns/1ps
module exs_mem_model (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// access request
	input  wire logic        req_i,
	input  wire logic [31:0] addr_i,
	// answer
	output logic             ack_o,
	output logic [31:0]      rdata_o
);
	logic [1:0] wait_cnt;
	logic [1:0] pace;
	// ----------------
	// answer pacing
	// ----------------
	// the wait walks 0..2 so prompt and slow answers both occur
	always_ff @(posedge clk_i) begin
		ack_o <= 1'b0;
		// data is only valid with the ack, it flips otherwise
		rdata_o <= ~rdata_o;
		if (rst_i) begin
			pace <= 2'h0;
			wait_cnt <= 2'h0;
			rdata_o <= 32'h0;
		end else if (!req_i || ack_o) begin
			wait_cnt <= pace;
			pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
		end else if (wait_cnt == 2'h0) begin
			ack_o <= 1'b1;
			rdata_o <= {addr_i[15:0], 16'hc0de};
		end else begin
			wait_cnt <= wait_cnt - 2'h1;
		end
	end
endmodule : exs_mem_model

/* File: dv/exs_sequencer_assertions.sv */
// port checks for the exception entry sequencer
`timescale 1ns/1ps
module exs_sequencer_assertions
	import exs_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	// clock, reset and sources
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic              power_on_reset_pin_n_i,
	input wire logic              insn_done_i,
	input wire logic [31:0]       sp_i,
	input wire logic [31:0]       status_word_i,
	// memory bus
	input wire logic              mem_req_o,
	input wire logic              mem_we_o,
	input wire logic [ADDR_W-1:0] mem_addr_o,
	input wire logic [31:0]       mem_wdata_o,
	input wire logic              mem_ack_i,
	input wire logic [31:0]       mem_rdata_i,
	// results
	input wire logic              redirect_o,
	input wire logic [31:0]       new_pc_o,
	input wire logic [31:0]       vector_base_reg_o,
	input wire logic [31:0]       status_word_o,
	input wire logic              ack_src_o,
	input wire exs_src_type       ack_src_kind_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----------------
	// reset entry steps
	// ----------------
	sequence pc_slot_read;
		mem_req_o && mem_ack_i && !mem_we_o && mem_addr_o == 32'h0 && ack_src_kind_o == SRC_POR;
	endsequence
	sequence sp_slot_req;
		mem_req_o && !mem_we_o && mem_addr_o == 32'h4;
	endsequence
	por_start_a: assert property ($rose(power_on_reset_pin_n_i) |-> ##[1:3] (ack_src_o && ack_src_kind_o == SRC_POR))
		else $error("power-on entry late");
	por_vec_a: assert property (pc_slot_read |-> ##[1:20] sp_slot_req)
		else $error("power-on sp slot not read");
	man_vec_a: assert property (ack_src_o && ack_src_kind_o == SRC_MANUAL |-> mem_req_o && !mem_we_o && mem_addr_o == 32'h8)
		else $error("manual pc slot wrong");
	reset_state_a: assert property (redirect_o && ack_src_kind_o inside {SRC_POR, SRC_MANUAL} |-> vector_base_reg_o == 32'h0 && status_word_o[7:4] == 4'hf)
		else $error("reset state wrong");
	// ----------------
	// other entries
	// ----------------
	early_entry_a: assert property (ack_src_o && ack_src_kind_o inside {[SRC_CPU_AE:SRC_PERIPH]} |-> $past(insn_done_i))
		else $error("accepted before completion");
	push_sr_a: assert property (ack_src_o && ack_src_kind_o >= SRC_CPU_AE |-> mem_req_o && mem_we_o && mem_addr_o == $past(sp_i) - 32'h4 && mem_wdata_o == $past(status_word_i))
		else $error("status push wrong");
	keep_mask_a: assert property (redirect_o && ack_src_kind_o inside {SRC_CPU_AE, SRC_DMA_AE, SRC_TRAP, SRC_GEN_ILL, SRC_SLOT_ILL} |-> status_word_o[7:4] == status_word_i[7:4])
		else $error("mask changed");
	jump_target_a: assert property (redirect_o && ack_src_kind_o >= SRC_CPU_AE |-> $past(mem_ack_i) && new_pc_o == $past(mem_rdata_i))
		else $error("handler address wrong");
	nmi_addr_a: assert property (mem_req_o && !mem_we_o && ack_src_kind_o == SRC_NMI |-> mem_addr_o == vector_base_reg_o + 32'h2c)
		else $error("nmi vector address wrong");
endmodule : exs_sequencer_assertions

bind exs_sequencer exs_sequencer_assertions #(.ADDR_W(ADDR_W)) chk (.*);

/* File: dv/tb_exs_sequencer.sv */
// self-checking bench for the exception entry sequencer
`timescale 1ns/1ps
module tb_exs_sequencer;
	import exs_pkg::*;
`define CHK(n, e, a) begin samples_checked++; if ((e) !== (a)) begin fails++; \
$display("MISMATCH %s exp %h got %h", n, e, a); end end
	logic        clk_i = 1'b0, rst_i = 1'b1, power_on_reset_pin_n_i = 1'b0, manual_reset_pin_n_i = 1'b1;
	logic        dec_valid_i = 1'b0, insn_done_i = 1'b1, mem_req_o, mem_we_o, mem_ack_i, pipe_hold_o;
	logic        redirect_o, sp_we_o, periph_reset_o, ack_src_o;
	logic        cpu_addr_err_i, dma_addr_err_i, nmi_i, user_break_i, irq_i, periph_i;
	logic [5:0]  src = 6'h0;
	logic [15:0] e;
	logic [31:0] pc_i = 32'h1234, sp_i = 32'h8000, status_word_i = 32'hf0;
	logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i, new_pc_o, new_sp_o, vector_base_reg_o, status_word_o;
	logic [7:0]  trap_vec_i = 8'h20, irq_vec_i = 8'h40, periph_vec_i = 8'h48;
	logic [3:0]  irq_level_i = 4'h3, periph_level_i = 4'h2, nmi_level_i = 4'hf, ubrk_level_i = 4'he;
	logic [64:0] log_q[$];
	exs_op_type  dec_op_i = OP_OTHER;
	exs_src_type ack_src_kind_o;
	int          fails = 0, samples_checked = 0, seed = 64206;

	assign {cpu_addr_err_i, dma_addr_err_i, nmi_i, user_break_i, irq_i, periph_i} = src;
	exs_sequencer dut (.*);
	exs_mem_model mem (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.req_i   (mem_req_o),
		.addr_i  (mem_addr_o),
		.ack_o   (mem_ack_i),
		.rdata_o (mem_rdata_i)
	);
	initial forever #25 clk_i = ~clk_i;
	always @(posedge clk_i)
		if (mem_req_o && mem_ack_i)
			log_q.push_back({mem_we_o, mem_addr_o, mem_wdata_o});
	// ----------------
	// helpers
	// ----------------
	function automatic logic [31:0] mword(input logic [31:0] a);
		mword = {a[15:0], 16'hc0de};
	endfunction : mword
	function automatic logic [15:0] expect_of(input int b);
		case (b)
			5: expect_of = {SRC_CPU_AE, VEC_CPU_ADDR_ERR, status_word_i[7:4]};
			4: expect_of = {SRC_DMA_AE, VEC_DMA_ADDR_ERR, status_word_i[7:4]};
			3: expect_of = {SRC_NMI, VEC_NMI, nmi_level_i};
			2: expect_of = {SRC_UBRK, VEC_USER_BREAK, ubrk_level_i};
			1: expect_of = {SRC_IRQ, irq_vec_i, irq_level_i};
			default: expect_of = {SRC_PERIPH, periph_vec_i, periph_level_i};
		endcase
	endfunction : expect_of
	task automatic tick;
		@(posedge clk_i);
		#5;
	endtask : tick
	task automatic wait_hi(ref logic s);
		for (int i = 0; i < 80 && s !== 1'b1; i++) begin
			@(posedge clk_i);
			#1;
		end
		`CHK("handshake", 1'b1, s)
	endtask : wait_hi
	task automatic issue(input exs_op_type o);
		dec_op_i = o;
		dec_valid_i = 1'b1;
		tick;
		dec_valid_i = 1'b0;
		dec_op_i = OP_OTHER;
	endtask : issue
	task automatic entry(input exs_src_type k, input logic [7:0] v, input logic [3:0] m, input int b);
		logic [31:0] va;
		va = {22'h0, v, 2'h0};
		wait_hi(ack_src_o);
		log_q.delete();
		`CHK("source", k, ack_src_kind_o)
		if (b >= 0) begin
			tick;
			src[b] = 1'b0;
		end
		wait_hi(redirect_o);
		`CHK("sr push", {1'b1, sp_i - 32'h4, status_word_i}, log_q[0])
		`CHK("pc push", {1'b1, sp_i - 32'h8, pc_i}, log_q[1])
		`CHK("vector read", {1'b0, va}, log_q[2][64:32])
		`CHK("new pc", mword(va), new_pc_o)
		`CHK("new sp", sp_i - 32'h8, new_sp_o)
		`CHK("mask", m, status_word_o[7:4])
		`CHK("sp write", 1'b1, sp_we_o)
		`CHK("hold", 1'b1, pipe_hold_o)
		tick;
		status_word_i = status_word_o;
	endtask : entry
	task automatic do_reset(input logic man);
		logic [31:0] b;
		b = man ? 32'h8 : 32'h0;
		if (man)
			manual_reset_pin_n_i = 1'b0;
		repeat (3) tick;
		`CHK("periph reset", ~man, periph_reset_o)
		power_on_reset_pin_n_i = 1'b1;
		manual_reset_pin_n_i = 1'b1;
		wait_hi(ack_src_o);
		log_q.delete();
		`CHK("reset kind", man ? SRC_MANUAL : SRC_POR, ack_src_kind_o)
		wait_hi(redirect_o);
		`CHK("pc slot", {1'b0, b}, log_q[0][64:32])
		`CHK("sp slot", {1'b0, b + 32'h4}, log_q[1][64:32])
		`CHK("start pc", mword(b), new_pc_o)
		`CHK("start sp", mword(b + 32'h4), new_sp_o)
		`CHK("base", 32'h0, vector_base_reg_o)
		`CHK("reset mask", 4'hf, status_word_o[7:4])
		`CHK("start sp write", 1'b1, sp_we_o)
		tick;
		status_word_i = status_word_o;
	endtask : do_reset
	task automatic wrap_up;
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	// ----------------
	// scenarios
	// ----------------
	initial begin
		int b;
		repeat (2) @(posedge clk_i);
		#5;
		rst_i = 1'b0;
		do_reset(1'b0);
		// mixes of pending sources drain in rank order
		for (int t = 0; t < 10; t++) begin
			src = (t == 0) ? 6'h3f : 6'($random(seed)) | 6'h1;
			{irq_level_i, periph_level_i, irq_vec_i[2:0], periph_vec_i[2:0]} = 14'($random(seed));
			sp_i = {16'h1, 14'($random(seed)), 2'h0};
			pc_i = $random(seed);
			while (src != 6'h0) begin
				for (int i = 0; i < 6; i++)
					if (src[i])
						b = i;
				e = expect_of(b);
				entry(exs_src_type'(e[15:12]), e[11:4], e[3:0], b);
			end
		end
		insn_done_i = 1'b0;
		src = 6'h02;
		repeat (4) begin
			tick;
			`CHK("early accept", 1'b0, ack_src_o)
		end
		insn_done_i = 1'b1;
		e = expect_of(1);
		entry(SRC_IRQ, e[11:4], e[3:0], 1);
		do_reset(1'b1);
		trap_vec_i = {3'h1, 5'($random(seed))};
		issue(OP_SOFTWARE_TRAP);
		entry(SRC_TRAP, trap_vec_i, status_word_i[7:4], -1);
		issue(OP_BRANCH);
		tick;
		issue(OP_OTHER);
		tick;
		issue(OP_BRANCH_TRUE);
		tick;
		issue(OP_UNDEFINED);
		entry(SRC_GEN_ILL, VEC_GEN_ILLEGAL, status_word_i[7:4], -1);
		for (int j = 0; j < 14; j++) begin
			issue(exs_op_type'(2 + j % 10));
			tick;
			issue(j == 13 ? OP_UNDEFINED : exs_op_type'(2 + j));
			entry(SRC_SLOT_ILL, VEC_SLOT_ILLEGAL, status_word_i[7:4], -1);
		end
		wrap_up;
	end
	initial begin
		#1000000;
		fails++;
		$display("MISMATCH watchdog exp done got hang");
		wrap_up;
	end
endmodule : tb_exs_sequencer
